// *** hdl/sadc_pkg.sv ***
// Constants shared by the converter control block.
// Assumes a 25 MHz system clock and a classic Wishbone register bus.
package sadc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] SADC_IDX_CTRL    = 10'h070;
  localparam logic [9:0] SADC_IDX_RES_HI  = 10'h071;
  localparam logic [9:0] SADC_IDX_RES_LO  = 10'h072;
  localparam int         SADC_ADR_W       = 12;
  localparam int         SADC_DAT_W       = 32;

  // Control/status field positions
  localparam int         SADC_BIT_DONE    = 7;
  localparam int         SADC_BIT_SPEED   = 6;
  localparam int         SADC_BIT_ON      = 5;
  localparam int         SADC_CH_MSB      = 3;
  localparam int         SADC_CH_LSB      = 0;
  localparam logic [7:0] SADC_CTRL_RESET  = 8'h00;

  // Result layout
  localparam int         SADC_RES_W       = 10;
  localparam int         SADC_CH_W        = 4;
  localparam logic [9:0] SADC_RES_FULL    = 10'h3ff;
  localparam logic [9:0] SADC_RES_ZERO    = 10'h000;

  // Converter clock divide: speed bit clear -> /4, set -> /2
  localparam logic [1:0] SADC_DIV_SLOW    = 2'h3;
  localparam logic [1:0] SADC_DIV_FAST    = 2'h1;

  // Sampling phase length in converter ticks
  localparam int         SADC_SAMPLE_TICKS = 3;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_state_t;
endpackage : sadc_pkg

// *** hdl/sadc_clkdiv.sv ***
// Converter clock enable: one-cycle tick at clk/4 or clk/2.
// Assumes a single system clock; the tick is an enable, not a clock.
module sadc_clkdiv
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic fast_i,
  // Tick
  output logic      tick_o
);
  logic [1:0] cnt_ff;
  logic [1:0] lim;

  assign lim = fast_i ? SADC_DIV_FAST : SADC_DIV_SLOW;

  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_ff >= lim) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff >= lim);
    end
  end
endmodule // sadc_clkdiv

// *** hdl/sadc_sar.sv ***
// Successive-approximation sequencer: sampling, then ten trial steps.
// Assumes comp_i is high when the held input is at or above the trial code.
module sadc_sar
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control
  input  wire logic                  tick_i,
  input  wire logic                  run_i,
  input  wire logic                  restart_i,
  // Analog side
  input  wire logic                  comp_i,
  output logic                       sample_o,
  output logic [SADC_RES_W-1:0]      trial_o,
  // Result
  output logic                       done_o,
  output logic [SADC_RES_W-1:0]      result_o
);
  sadc_state_t state_ff;
  logic [3:0]  step_ff;
  logic [3:0]  last_step;

  assign last_step = 4'(SADC_SAMPLE_TICKS - 1);

  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || !run_i) begin
      state_ff <= SADC_IDLE;
      step_ff  <= 4'h0;
      sample_o <= 1'b0;
      trial_o  <= SADC_RES_ZERO;
      result_o <= SADC_RES_ZERO;
    end else if (restart_i) begin
      // Abort: drop partial result and resample at once
      state_ff <= SADC_SAMPLE;
      step_ff  <= 4'h0;
      sample_o <= 1'b1;
      trial_o  <= SADC_RES_ZERO;
    end else begin
      unique case (state_ff)
        SADC_IDLE: begin
          state_ff <= SADC_SAMPLE;
          step_ff  <= 4'h0;
          sample_o <= 1'b1;
        end
        SADC_SAMPLE: begin
          if (tick_i) begin
            if (step_ff == last_step) begin
              state_ff <= SADC_CONVERT;
              step_ff  <= 4'(SADC_RES_W - 1);
              sample_o <= 1'b0;
              trial_o  <= {1'b1, {(SADC_RES_W-1){1'b0}}};
            end else begin
              step_ff <= step_ff + 4'h1;
            end
          end
        end
        SADC_CONVERT: begin
          if (tick_i) begin
            // Keep or drop the bit under test, then try the next lower one
            if (!comp_i) begin
              trial_o[step_ff] <= 1'b0;
            end
            if (step_ff == 4'h0) begin
              result_o <= comp_i ? trial_o : (trial_o & ~SADC_RES_W'(1));
              done_o   <= 1'b1;
              state_ff <= SADC_SAMPLE;
              sample_o <= 1'b1;
            end else begin
              trial_o[step_ff - 4'h1] <= 1'b1;
              step_ff <= step_ff - 4'h1;
            end
          end
        end
      endcase
    end
  end
endmodule // sadc_sar

// *** hdl/sadc_top.sv ***
// Converter control: Wishbone registers, channel select, SAR sequencing.
// Assumes an external sample-hold, 16-way mux, trial DAC and comparator.
module sadc_top
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [SADC_ADR_W-1:0]      adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [SADC_DAT_W-1:0]      dat_i,
  output logic      [SADC_DAT_W-1:0]      dat_o,
  output logic                            ack_o,
  // Power mode
  input  wire logic                       halt_i,
  // Analog front end
  input  wire logic                       comp_i,
  output logic      [SADC_CH_W-1:0]       mux_sel_o,
  output logic                            sample_o,
  output logic      [SADC_RES_W-1:0]      trial_o,
  output logic                            conv_power_o
);
  import sadc_pkg::*;

  logic                    speed_ff;
  logic                    conv_on_ff;
  logic                    done_ff;
  logic [SADC_CH_W-1:0]    channel_ff;
  logic [SADC_RES_W-1:0]   result_ff;
  logic                    restart_ff;

  logic                    accept;
  logic                    wr_ctrl;
  logic                    rd_hi;
  logic                    chan_change;
  logic [9:0]              idx;
  logic [7:0]              nxt_rdata;
  logic                    tick;
  logic                    run;
  logic                    sar_done;
  logic [SADC_RES_W-1:0]   sar_result;

  // Bus decode
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    return a == r;
  endfunction

  assign idx     = adr_i[SADC_ADR_W-1:2];
  assign accept  = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = accept && we_i && sel_i[0] && hit(idx, SADC_IDX_CTRL);
  assign rd_hi   = accept && !we_i && hit(idx, SADC_IDX_RES_HI);
  assign chan_change = wr_ctrl && (dat_i[SADC_CH_MSB:SADC_CH_LSB] != channel_ff);
  // on bit gates the sequencer; there is no wait input at all
  // no interrupt output; software polls the done flag
  assign run = conv_power_o;

  // Ack one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= accept;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(idx, SADC_IDX_CTRL)) begin
      nxt_rdata = {done_ff, speed_ff, conv_on_ff, 1'b0, channel_ff};
    end else if (hit(idx, SADC_IDX_RES_HI)) begin
      nxt_rdata = result_ff[9:2];
    end else if (hit(idx, SADC_IDX_RES_LO)) begin
      nxt_rdata = {6'h00, result_ff[1:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (accept && !we_i) begin
      dat_o <= {24'h000000, nxt_rdata};
    end
  end

  // Control fields; reserved bit 4 is not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_ff   <= SADC_CTRL_RESET[SADC_BIT_SPEED];
      conv_on_ff <= SADC_CTRL_RESET[SADC_BIT_ON];
      channel_ff <= SADC_CTRL_RESET[SADC_CH_MSB:SADC_CH_LSB];
    end else if (wr_ctrl) begin
      speed_ff   <= dat_i[SADC_BIT_SPEED];
      conv_on_ff <= dat_i[SADC_BIT_ON];
      channel_ff <= dat_i[SADC_CH_MSB:SADC_CH_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_sel_o <= '0;
    end else begin
      mux_sel_o <= channel_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_power_o <= 1'b0;
    end else begin
      conv_power_o <= conv_on_ff && !halt_i;
    end
  end

  // Restart lands with the new mux select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= chan_change;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (sar_done && !restart_ff) begin
      done_ff <= 1'b1;
    // clear on high read or control register write
    end else if (rd_hi || wr_ctrl) begin
      done_ff <= 1'b0;
    end
  end

  // overwrite on each completion not met by a restart, no latching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= SADC_RES_ZERO;
    end else if (sar_done && !restart_ff) begin
      result_ff <= sar_result;
    end
  end

  sadc_clkdiv u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .fast_i (speed_ff),
    .tick_o (tick)
  );

  // comparator saturates naturally at 3ffh and 000h
  sadc_sar u_sar (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .run_i     (run),
    .restart_i (restart_ff),
    .comp_i    (comp_i),
    .sample_o  (sample_o),
    .trial_o   (trial_o),
    .done_o    (sar_done),
    .result_o  (sar_result)
  );

  // Checks next to the logic they guard
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hi_read;
    rd_hi && !sar_done;
  endsequence

  sequence s_done_loaded;
    done_ff && result_ff == $past(sar_result);
  endsequence

  property p_hi_read_clears;
    s_hi_read |=> !done_ff;
  endproperty
  a_hi_read_clears: assert property (p_hi_read_clears)
    else $error("done flag kept after high result read");

  property p_write_clears;
    wr_ctrl && !sar_done |=> !done_ff;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("done flag kept after control write");

  property p_done_sets;
    sar_done && !restart_ff |=> s_done_loaded;
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("completion did not load result and flag");

  property p_chan_restart;
    chan_change && conv_power_o && conv_on_ff && dat_i[SADC_BIT_ON] && !halt_i
      |=> ##1 sample_o && !done_ff;
  endproperty
  a_chan_restart: assert property (p_chan_restart)
    else $error("channel change did not restart sampling");

  property p_off_stops;
    !conv_on_ff |=> !conv_power_o ##1 !sample_o;
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("converter still running after off");

  property p_halt_off;
    halt_i |=> !conv_power_o ##1 !sample_o;
  endproperty
  a_halt_off: assert property (p_halt_off)
    else $error("converter powered during halt");

  property p_low_read;
    ack_o && !$past(we_i) && $past(hit(idx, SADC_IDX_RES_LO))
      |-> dat_o[7:2] == 6'h00 && dat_o[1:0] == $past(result_ff[1:0]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low result read bad");

  property p_full_scale;
    sar_done && !restart_ff && sar_result == SADC_RES_FULL
      |=> result_ff[9:2] == 8'hff && result_ff[1:0] == 2'h3;
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("full scale not reported");

  property p_zero_scale;
    sar_done && !restart_ff && sar_result == SADC_RES_ZERO
      |=> result_ff == SADC_RES_ZERO;
  endproperty
  a_zero_scale: assert property (p_zero_scale)
    else $error("zero scale not reported");

  property p_high_read;
    ack_o && !$past(we_i) && $past(hit(idx, SADC_IDX_RES_HI))
      |-> dat_o[31:8] == 24'h000000 && dat_o[7:0] == $past(result_ff[9:2]);
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high result read bad");

  // Slow tick: at least two quiet cycles after each tick unless speed is rewritten
  property p_tick_slow;
    tick && !speed_ff && !wr_ctrl |=> !tick ##1 !tick;
  endproperty
  a_tick_slow: assert property (p_tick_slow)
    else $error("slow converter tick too frequent");

  property p_tick_fast;
    tick && speed_ff && !wr_ctrl |=> !tick ##1 tick;
  endproperty
  a_tick_fast: assert property (p_tick_fast)
    else $error("fast converter tick not every second cycle");

  property p_continuous;
    conv_power_o && !chan_change && !restart_ff && !wr_ctrl
      |-> ##[0:200] (sar_done || !conv_power_o || wr_ctrl);
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("no completion while converter on");

  property p_mux_follows;
    1'b1 |=> mux_sel_o == $past(channel_ff);
  endproperty
  a_mux_follows: assert property (p_mux_follows)
    else $error("mux select does not follow channel");
endmodule // sadc_top

// *** testbench/sadc_afe_model.sv ***
// Analog front end model: 16 input levels, sample-hold, comparator.
// Assumes the trial code and channel come from the converter control block.
module sadc_afe_model
  import sadc_pkg::*;
(
  // Clock
  input  wire logic                  clk_i,
  // From the block
  input  wire logic [SADC_CH_W-1:0]  mux_sel_i,
  input  wire logic                  sample_i,
  input  wire logic [SADC_RES_W-1:0] trial_i,
  input  wire logic                  power_i,
  input  wire logic [10:0]           lvl_i [16],
  // To the block
  output logic                       comp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] held_ff;
  logic        junk_ff = 1'b0;

  // mux routes channel; levels are plain inputs
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_ff <= lvl_i[mux_sel_i];
    end
  end

  // Free-running noise source, kept apart from the hold logic
  always @(posedge clk_i) begin
    junk_ff <= ~junk_ff;
  end

  // saturating comparator; unpowered output is noise
  assign comp_o = power_i ? (held_ff >= {1'b0, trial_i}) : junk_ff;
endmodule // sadc_afe_model

// *** testbench/sar_adc_control_tb_top.sv ***
// Self-checking bench for the converter control block.
// Assumes the analog model answers the comparator; Wishbone master is here.
module sar_adc_control_tb_top;
  import sadc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_CTRL = {SADC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_HI   = {SADC_IDX_RES_HI, 2'b00};
  localparam logic [11:0] A_LO   = {SADC_IDX_RES_LO, 2'b00};

  logic        clk_i, rst_i, cyc, stb, we, ack_o, halt_i, comp, sample, pwr;
  logic [11:0] adr;
  logic [3:0]  sel, mux_sel;
  logic [31:0] dat, dat_o;
  logic [9:0]  trial;
  logic [10:0] lvl [16];
  int          num_errors, n_compared, cycles;

  sadc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .halt_i(halt_i),
    .comp_i(comp), .mux_sel_o(mux_sel), .sample_o(sample), .trial_o(trial),
    .conv_power_o(pwr));
  sadc_afe_model i_afe (.clk_i(clk_i), .mux_sel_i(mux_sel), .sample_i(sample),
    .trial_i(trial), .power_i(pwr), .lvl_i(lvl), .comp_o(comp));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= 4'h1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  function automatic logic [9:0] sat(input logic [10:0] v);
    return v[10] ? 10'h3ff : v[9:0];
  endfunction

  task automatic wait_done();
    logic [7:0] q;
    int         n;
    n = 0;
    do begin wb(1'b0, A_CTRL, 8'h00, q); n++; end while (q[7] !== 1'b1 && n < 100);
    chk({7'h0, q[7]}, 8'h01);
  endtask

  task automatic rd_full(input logic [9:0] e);
    logic [7:0] q;
    wb(1'b0, A_LO, 8'h00, q);
    chk(q, {6'h0, e[1:0]});
    wb(1'b0, A_HI, 8'h00, q);
    chk(q, e[9:2]);
  endtask

  task automatic t_reset();
    logic [7:0] q;
    wb(1'b0, A_CTRL, 8'h00, q);
    chk(q, SADC_CTRL_RESET);
    wr(A_HI, 8'h5a);
    wb(1'b0, A_HI, 8'h00, q);
    chk(q, 8'h00);
    wb(1'b0, 12'h3f0, 8'h00, q);
    chk(q, 8'h00);
  endtask

  // Each channel write after the first lands mid-conversion of the previous one
  task automatic t_channels();
    logic [7:0] q, c;
    for (int i = 0; i < 16; i++) begin
      c = {1'b0, i[0], 1'b1, 1'b0, i[3:0]};
      wr(A_CTRL, c);
      chk({4'h0, mux_sel}, {4'h0, i[3:0]});
      wait_done();
      rd_full(sat(lvl[i]));
      wb(1'b0, A_CTRL, 8'h00, q);
      chk(q, c);
    end
  endtask

  task automatic t_continuous();
    logic [7:0] q;
    wr(A_CTRL, 8'h23);
    wait_done();
    wb(1'b0, A_HI, 8'h00, q);
    chk(q, 8'(sat(lvl[3]) >> 2));
    lvl[3] <= 11'h155;
    wait_done();
    wb(1'b0, A_HI, 8'h00, q);
    wait_done();
    rd_full(10'h155);
    wait_done();
    wr(A_CTRL, 8'hb3);
    wb(1'b0, A_CTRL, 8'h00, q);
    chk(q, 8'h23);
  endtask

  task automatic t_power();
    logic [7:0] q;
    wr(A_CTRL, 8'h03);
    chk({7'h0, pwr}, 8'h00);
    repeat (150) @(posedge clk_i);
    wb(1'b0, A_CTRL, 8'h00, q);
    chk(q, 8'h03);
    wr(A_CTRL, 8'h63);
    halt_i <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk({7'h0, pwr}, 8'h00);
    wb(1'b0, A_CTRL, 8'h00, q);
    chk(q, 8'h63);
    halt_i <= 1'b0;
    wait_done();
    chk({7'h0, pwr}, 8'h01);
    rd_full(10'h155);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    num_errors = 0; n_compared = 0; cycles = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000;
    sel = 4'h0; dat = 32'h0; halt_i = 1'b0;
    for (int i = 0; i < 14; i++) lvl[i] = 11'(i * 67 + 5);
    lvl[14] = 11'h5ff;
    lvl[15] = 11'h000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_channels();
    t_continuous();
    t_power();
    end_sim();
  end
endmodule // sar_adc_control_tb_top
